// file: verilog/hoc_map.vh
// Constants for the harmonic overcurrent stage
`ifndef HOC_MAP_VH
`define HOC_MAP_VH
`define HARM_SEL_W 4
`define HARM_SEL_DEFAULT 4'h0
`define HARM_COUNT 13
`define MODE_PER_UNIT 1'b0
`define MODE_RELATIVE 1'b1
`define INPUT_PHASE 2'h0
`define INPUT_RES1 2'h1
`define INPUT_RES2 2'h2
`define THR_W 16
`define PU_THR_MIN 16'h0005
`define PU_THR_MAX 16'h00C8
`define PU_THR_DEFAULT 16'h0014
`define REL_THR_MIN 16'h01F4
`define REL_THR_MAX 16'h4E20
`define REL_THR_DEFAULT 16'h07D0
`define RESET_RATIO_PCT 8'h61
`define COND_NORMAL 2'h0
`define COND_START 2'h1
`define COND_TRIP 2'h2
`define COND_BLOCKED 2'h3
`define TIME_RES_MS 5
`endif

// file: verilog/harmonic_pick.v
// Per-channel harmonic selection and scaling to the monitored magnitude
`include "hoc_map.vh"
module harmonic_pick #(
  parameter MAG_W = 16
) (
  input wire [MAG_W*14-1:0] spectrum,
  input wire [3:0] harm_sel,
  input wire rel_mode,
  output reg [MAG_W-1:0] measured_magnitude
);
  reg [MAG_W-1:0] fund;
  reg [MAG_W-1:0] harm;
  reg [MAG_W+13:0] scaled;
  reg [MAG_W+13:0] quot;
  always @* begin
    fund = spectrum[MAG_W-1:0];
    // Out-of-range selection falls back to the second harmonic
    if (harm_sel < `HARM_COUNT) begin
      harm = spectrum[MAG_W*harm_sel+MAG_W +: MAG_W];
    end else begin
      harm = spectrum[MAG_W +: MAG_W];
    end
    scaled = {14'h0000, harm} * 30'h00002710;
    quot = {(MAG_W+14){1'b0}};
    if (rel_mode == `MODE_RELATIVE) begin
      // Percent with two decimals; zero fundamental reads as full scale
      if (fund == {MAG_W{1'b0}}) begin
        measured_magnitude = {MAG_W{1'b1}};
      end else begin
        // Divide the full product; cutting it first would wrap large ratios
        quot = scaled / {14'h0000, fund};
        if (quot > {{14{1'b0}}, {MAG_W{1'b1}}}) begin
          measured_magnitude = {MAG_W{1'b1}};
        end else begin
          measured_magnitude = quot[MAG_W-1:0];
        end
      end
    end else begin
      measured_magnitude = harm;
    end
  end
endmodule // harmonic_pick

// file: verilog/level_compare.v
// Threshold comparison with a fixed 97 percent release point
`include "hoc_map.vh"
module level_compare #(
  parameter MAG_W = 16
) (
  input wire [MAG_W-1:0] level,
  input wire [MAG_W-1:0] threshold,
  input wire picked,
  output wire over
);
  wire [MAG_W+7:0] lvl_x100;
  wire [MAG_W+7:0] thr_x97;
  assign lvl_x100 = {8'h00, level} * 8'h64;
  assign thr_x97 = {8'h00, threshold} * `RESET_RATIO_PCT;
  // Pick-up above setting, hold until below 97 percent of it
  assign over = picked ? (lvl_x100 >= thr_x97) : (level > threshold);
endmodule // level_compare

// file: verilog/harmonic_overcurrent_stage.v
// Harmonic overcurrent stage: pick-up, blocking, forcing and readouts
`include "hoc_map.vh"
module harmonic_overcurrent_stage #(
  parameter MAG_W = 16,
  parameter TIME_W = 20,
  parameter OPERATE_TICKS = 20'h00064,
  parameter RELEASE_TICKS = 20'h00000
) (
  input wire clk,
  input wire sys_rst,
  input wire cycle_strobe,
  input wire tick_5ms,
  input wire [MAG_W*14-1:0] phase_a_spectrum,
  input wire [MAG_W*14-1:0] phase_b_spectrum,
  input wire [MAG_W*14-1:0] phase_c_spectrum,
  input wire [MAG_W*14-1:0] first_residual_channel,
  input wire [MAG_W*14-1:0] second_residual_channel,
  input wire [3:0] harm_sel,
  input wire rel_mode,
  input wire [1:0] input_sel,
  input wire [15:0] per_unit_pickup_threshold,
  input wire [15:0] relative_harmonic_threshold,
  input wire settings_load,
  input wire block_in,
  input wire force_enable,
  input wire [1:0] force_state,
  output reg start_q,
  output reg trip_q,
  output reg blocked_q,
  output reg [1:0] condition_q,
  output reg [31:0] ratio_q,
  output reg [TIME_W-1:0] expected_time_q,
  output reg signed [TIME_W:0] remaining_time_q,
  output reg [MAG_W-1:0] measured_magnitude_q
);
  // Active setting group, swapped live on load
  reg [3:0] harm_sel_q;
  reg rel_mode_q;
  reg [1:0] input_sel_q;
  reg [15:0] pu_thr_q;
  reg [15:0] rel_thr_q;
  reg block_smp_q;
  reg picked_q;
  reg [TIME_W-1:0] op_cnt_q;
  reg [TIME_W-1:0] rel_cnt_q;
  reg [1:0] state_q;
  reg [1:0] state_d;

  localparam ST_NORMAL = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_TRIP = 2'h2;
  localparam ST_BLOCKED = 2'h3;

  function [15:0] clamp_thr;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if (v < lo) begin
        clamp_thr = lo;
      end else if (v > hi) begin
        clamp_thr = hi;
      end else begin
        clamp_thr = v;
      end
    end
  endfunction

  always @(posedge clk) begin
    if (sys_rst) begin
      harm_sel_q <= `HARM_SEL_DEFAULT;
      rel_mode_q <= `MODE_PER_UNIT;
      input_sel_q <= `INPUT_PHASE;
      pu_thr_q <= `PU_THR_DEFAULT;
      rel_thr_q <= `REL_THR_DEFAULT;
    end else if (settings_load) begin
      // No restart: pick-up state and timers carry over
      harm_sel_q <= harm_sel;
      rel_mode_q <= rel_mode;
      input_sel_q <= input_sel;
      pu_thr_q <= clamp_thr(per_unit_pickup_threshold, `PU_THR_MIN, `PU_THR_MAX);
      rel_thr_q <= clamp_thr(relative_harmonic_threshold, `REL_THR_MIN, `REL_THR_MAX);
    end
  end

  wire [MAG_W-1:0] mag_a;
  wire [MAG_W-1:0] mag_b;
  wire [MAG_W-1:0] mag_c;
  reg [MAG_W*14-1:0] sp_a;

  always @* begin
    case (input_sel_q)
      `INPUT_RES1: sp_a = first_residual_channel;
      `INPUT_RES2: sp_a = second_residual_channel;
      default: sp_a = phase_a_spectrum;
    endcase
  end

  harmonic_pick #(.MAG_W(MAG_W)) u_pick_a (
    .spectrum(sp_a),
    .harm_sel(harm_sel_q),
    .rel_mode(rel_mode_q),
    .measured_magnitude(mag_a)
  );
  harmonic_pick #(.MAG_W(MAG_W)) u_pick_b (
    .spectrum(phase_b_spectrum),
    .harm_sel(harm_sel_q),
    .rel_mode(rel_mode_q),
    .measured_magnitude(mag_b)
  );
  harmonic_pick #(.MAG_W(MAG_W)) u_pick_c (
    .spectrum(phase_c_spectrum),
    .harm_sel(harm_sel_q),
    .rel_mode(rel_mode_q),
    .measured_magnitude(mag_c)
  );

  wire phases_on;
  wire [MAG_W-1:0] thr;
  wire over_a;
  wire over_b;
  wire over_c;
  assign phases_on = (input_sel_q == `INPUT_PHASE) || (input_sel_q == 2'h3);
  assign thr = (rel_mode_q == `MODE_RELATIVE) ? rel_thr_q : pu_thr_q;

  level_compare #(.MAG_W(MAG_W)) u_cmp_a (
    .level(mag_a),
    .threshold(thr),
    .picked(picked_q),
    .over(over_a)
  );
  level_compare #(.MAG_W(MAG_W)) u_cmp_b (
    .level(mag_b),
    .threshold(thr),
    .picked(picked_q),
    .over(over_b)
  );
  level_compare #(.MAG_W(MAG_W)) u_cmp_c (
    .level(mag_c),
    .threshold(thr),
    .picked(picked_q),
    .over(over_c)
  );

  wire pick_now;
  assign pick_now = over_a | (phases_on & (over_b | over_c));

  reg [MAG_W-1:0] mag_max;
  always @* begin
    mag_max = mag_a;
    if (phases_on && mag_b > mag_max) begin
      mag_max = mag_b;
    end
    if (phases_on && mag_c > mag_max) begin
      mag_max = mag_c;
    end
  end

  // Block taken fresh each strobe, ahead of the pick-up decision
  always @(posedge clk) begin
    if (sys_rst) begin
      block_smp_q <= 1'b0;
    end else if (cycle_strobe) begin
      block_smp_q <= block_in;
    end
  end

  wire block_now;
  assign block_now = cycle_strobe ? block_in : block_smp_q;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_NORMAL: begin
        if (pick_now && block_now) begin
          state_d = ST_BLOCKED;
        end else if (pick_now) begin
          state_d = ST_START;
        end
      end
      ST_START: begin
        if (block_now) begin
          state_d = ST_NORMAL;
        end else if (!pick_now) begin
          state_d = ST_NORMAL;
        end else if (op_cnt_q + 1'b1 >= OPERATE_TICKS) begin
          state_d = ST_TRIP;
        end
      end
      ST_TRIP: begin
        if (!pick_now || block_now) begin
          state_d = ST_NORMAL;
        end
      end
      ST_BLOCKED: begin
        if (!pick_now) begin
          state_d = ST_NORMAL;
        end else if (!block_now) begin
          state_d = ST_START;
        end
      end
      default: state_d = ST_NORMAL;
    endcase
  end

  // Evaluation only on the processing strobe; 5 ms tick advances timers
  always @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_NORMAL;
      picked_q <= 1'b0;
      op_cnt_q <= {TIME_W{1'b0}};
      rel_cnt_q <= {TIME_W{1'b0}};
    end else if (cycle_strobe) begin
      state_q <= state_d;
      picked_q <= pick_now;
      if (state_d == ST_START && tick_5ms) begin
        op_cnt_q <= op_cnt_q + 1'b1;
      end else if (state_d != ST_START && state_d != ST_TRIP) begin
        // Release timing also runs when block drops an active START
        if (rel_cnt_q >= RELEASE_TICKS) begin
          op_cnt_q <= {TIME_W{1'b0}};
          rel_cnt_q <= {TIME_W{1'b0}};
        end else if (tick_5ms) begin
          rel_cnt_q <= rel_cnt_q + 1'b1;
        end
      end
    end
  end

  wire [31:0] ratio_num;
  assign ratio_num = {{(32-MAG_W){1'b0}}, mag_max} * 32'h00000064;

  always @(posedge clk) begin
    if (sys_rst) begin
      start_q <= 1'b0;
      trip_q <= 1'b0;
      blocked_q <= 1'b0;
      condition_q <= `COND_NORMAL;
      ratio_q <= 32'h00000000;
      expected_time_q <= {TIME_W{1'b0}};
      remaining_time_q <= {(TIME_W+1){1'b0}};
      measured_magnitude_q <= {MAG_W{1'b0}};
    end else begin
      if (force_enable) begin
        condition_q <= force_state;
        start_q <= (force_state == `COND_START);
        trip_q <= (force_state == `COND_TRIP);
        blocked_q <= (force_state == `COND_BLOCKED);
      end else begin
        condition_q <= state_q;
        start_q <= (state_q == ST_START);
        trip_q <= (state_q == ST_TRIP);
        blocked_q <= (state_q == ST_BLOCKED);
      end
      // Readouts latched per cycle so they hold between strobes
      if (cycle_strobe) begin
        ratio_q <= ratio_num / {16'h0000, thr};
        measured_magnitude_q <= mag_max;
      end
      expected_time_q <= OPERATE_TICKS;
      if (state_q == ST_START || state_q == ST_TRIP) begin
        remaining_time_q <= $signed({1'b0, OPERATE_TICKS}) - $signed({1'b0, op_cnt_q});
      end else begin
        remaining_time_q <= $signed({1'b0, OPERATE_TICKS});
      end
    end
  end
endmodule // harmonic_overcurrent_stage

// file: sim/hoc_checker_assertions.sv
// Port-level assertions for the harmonic overcurrent stage
`include "hoc_map.vh"
module hoc_checker #(
  parameter MAG_W = 16,
  parameter TIME_W = 20,
  parameter OPERATE_TICKS = 20'h00064
) (
  input wire clk,
  input wire sys_rst,
  input wire cycle_strobe,
  input wire settings_load,
  input wire block_in,
  input wire force_enable,
  input wire [1:0] force_state,
  input wire start_q,
  input wire trip_q,
  input wire blocked_q,
  input wire [1:0] condition_q,
  input wire [31:0] ratio_q,
  input wire [TIME_W-1:0] expected_time_q,
  input wire [MAG_W-1:0] measured_magnitude_q
);
  reg f1_q;
  reg f2_q;
  wire nf;
  // Forced outputs are excluded until forcing has been off two edges
  always @(posedge clk) begin
    f1_q <= force_enable;
    f2_q <= f1_q;
  end
  assign nf = !force_enable && !f1_q && !f2_q;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_reset_clears: assert property (disable iff (1'b0) sys_rst |=>
    !start_q && !trip_q && !blocked_q && condition_q == `COND_NORMAL)
    else $error("outputs not cleared by reset");
  a_readout_hold: assert property (!$past(cycle_strobe) && !$past(cycle_strobe, 2)
    && !$past(settings_load) && !$past(settings_load, 2) && !$past(sys_rst) && nf
    |-> $stable(start_q) && $stable(ratio_q) && $stable(measured_magnitude_q))
    else $error("outputs moved without a strobe");
  a_start_blocked_excl: assert property (!(start_q && blocked_q))
    else $error("start and blocked together");
  a_block_no_start: assert property (cycle_strobe && block_in ##1 nf ##1 nf
    |-> !start_q)
    else $error("start kept while blocked");
  a_cond_blocked: assert property (blocked_q && nf |-> condition_q == `COND_BLOCKED)
    else $error("condition does not show blocked");
  a_trip_after_start: assert property ($rose(trip_q) && nf |-> $past(start_q))
    else $error("trip without start");
  a_no_trip_blocked: assert property (blocked_q && nf |-> !trip_q)
    else $error("trip while blocked");
  a_force_cond: assert property ((force_enable && $stable(force_state)) [*3]
    |-> condition_q == force_state)
    else $error("forced condition not shown");
  a_op_time: assert property (!$past(sys_rst, 2) && $past(cycle_strobe, 2)
    |-> expected_time_q == OPERATE_TICKS)
    else $error("expected time wrong");
endmodule // hoc_checker

bind harmonic_overcurrent_stage hoc_checker #(.MAG_W(MAG_W), .TIME_W(TIME_W),
  .OPERATE_TICKS(OPERATE_TICKS)) chk_u (.clk, .sys_rst, .cycle_strobe, .settings_load,
  .block_in, .force_enable, .force_state, .start_q, .trip_q, .blocked_q, .condition_q,
  .ratio_q, .expected_time_q, .measured_magnitude_q);

// file: sim/front_end.sv
// Measurement front end model: spectra, cycle strobe and time tick
module front_end #(
  parameter MAG_W = 16
) (
  input wire logic clk,
  input wire logic tick_en,
  input wire logic [3:0] slot,
  input wire logic [MAG_W-1:0] fund,
  input wire logic [MAG_W-1:0] h [0:4],
  output logic cycle_strobe,
  output logic tick_5ms,
  output logic [MAG_W*14-1:0] sp [0:4]
);
  logic [MAG_W-1:0] cnt_q = '0;
  always @(posedge clk) cnt_q <= cnt_q + 1'b1;
  // One processing cycle every four clocks keeps the run short
  assign cycle_strobe = cnt_q[1:0] == 2'h3;
  assign tick_5ms = cycle_strobe && tick_en;
  // Unused slots churn so a wrong selection shows at once
  always_comb begin
    for (int c = 0; c < 5; c++) begin
      for (int k = 0; k < 14; k++) begin
        sp[c][k*MAG_W +: MAG_W] = k == 0 ? fund : k == slot + 1 ? h[c] : cnt_q ^ 16'h0F0F;
      end
    end
  end
endmodule // front_end

// file: sim/testbench.sv
// Self-checking bench for the harmonic overcurrent stage
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, sys_rst = 1, settings_load = 0, block_in = 0, rel_mode = 0;
  logic force_enable = 0, tick_en = 0;
  logic [1:0] input_sel = 0, force_state = 0;
  logic [3:0] harm_sel = 0, slot = 0;
  logic [15:0] put = 16'h0014, rht = 16'h07D0, fund = 16'h0064;
  logic [15:0] h [0:4] = '{default: 16'h0000};
  logic [223:0] sp [0:4];
  logic [31:0] rs = 32'hDB99;
  wire cycle_strobe, tick_5ms, start_q, trip_q, blocked_q;
  wire [1:0] condition_q;
  wire [31:0] ratio_q;
  wire [19:0] expected_time_q;
  wire signed [20:0] remaining_time_q;
  wire [15:0] measured_magnitude_q;
  int fails = 0, cmp_count = 0, thr, m, k, i, st = 0;
  bit pk = 0;
  initial forever #25 clk = ~clk;
  front_end fe_u (.clk, .tick_en, .slot, .fund, .h, .cycle_strobe, .tick_5ms, .sp);
  harmonic_overcurrent_stage #(.OPERATE_TICKS(20'h00003)) dut_u (.clk, .sys_rst,
    .cycle_strobe, .tick_5ms, .phase_a_spectrum(sp[0]), .phase_b_spectrum(sp[1]),
    .phase_c_spectrum(sp[2]), .first_residual_channel(sp[3]),
    .second_residual_channel(sp[4]), .harm_sel, .rel_mode, .input_sel,
    .per_unit_pickup_threshold(put), .relative_harmonic_threshold(rht), .settings_load,
    .block_in, .force_enable, .force_state, .start_q, .trip_q, .blocked_q, .condition_q,
    .ratio_q, .expected_time_q, .remaining_time_q, .measured_magnitude_q);
  function logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function int mg(logic [15:0] v);
    return rel_mode ? int'(v) * 10000 / int'(fund) : int'(v);
  endfunction
  task finish_test;
    $display("mismatches %0d, compares %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      $display("wrong value %s expected %0h seen %0h", n, e, s);
      fails++;
    end
  endtask
  task cyc;
    int n;
    n = 0;
    @(posedge clk);
    while (cycle_strobe !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    if (n == 8) begin
      fails++;
      finish_test();
    end
    thr = rel_mode ? (rht < 500 ? 500 : rht > 20000 ? 20000 : rht)
      : (put < 5 ? 5 : put > 200 ? 200 : put);
    m = 0;
    for (k = 0; k < 5; k++) begin
      if ((input_sel == 1 ? k == 3 : input_sel == 2 ? k == 4 : k < 3) && mg(h[k]) > m) m = mg(h[k]);
    end
    pk = pk ? m * 100 >= thr * 97 : m > thr;
    // Block during START falls to Normal first, then Blocked next cycle
    case (st)
      0: st = pk ? (block_in ? 3 : 1) : 0;
      1: st = (block_in || !pk) ? 0 : 1;
      2: st = (block_in || !pk) ? 0 : 2;
      default: st = !pk ? 0 : block_in ? 3 : 1;
    endcase
    repeat (2) @(posedge clk);
    #1;
    chk("magnitude", m, measured_magnitude_q);
    chk("ratio", m * 100 / thr, ratio_q);
    chk("start", st == 1, start_q);
    chk("blocked", st == 3, blocked_q);
    chk("trip state", st == 2, trip_q);
    chk("condition", st, condition_q);
  endtask
  task load;
    settings_load = 1;
    @(posedge clk);
    #1 settings_load = 0;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 sys_rst = 0;
    chk("reset condition", 0, condition_q);
    h[1] = 21;
    cyc();
    h[1] = 20;
    cyc();
    h[1] = 19;
    cyc();
    // Block is set in the same cycle as the pick-up, so the stage goes straight to Blocked
    h[0] = 50;
    block_in = 1;
    cyc();
    block_in = 0;
    cyc();
    block_in = 1;
    cyc();
    repeat (14) begin
      k = rnd();
      harm_sel = rs[3:0];
      slot = rs[3:0] > 12 ? 4'h0 : rs[3:0];
      rel_mode = rs[4];
      input_sel = rs[6:5] % 3;
      put = {8'h00, rs[15:8]};
      rht = 16'(rs[31:16] % 24000);
      block_in = rs[7] & rs[8];
      for (i = 0; i < 5; i++) h[i] = 16'(rnd() % (rel_mode ? 300 : 250));
      load();
      cyc();
    end
    for (i = 0; i < 4; i++) begin
      force_enable = 1;
      force_state = 2'(i);
      repeat (4) @(posedge clk);
      #1 chk("forced", i, condition_q);
    end
    force_enable = 0;
    {harm_sel, slot, rel_mode, input_sel, put, block_in} = {11'h000, 16'h0014, 1'b0};
    h = '{default: 16'h0032};
    load();
    cyc();
    tick_en = 1;
    k = 0;
    while (trip_q !== 1'b1 && k < 40) begin
      @(posedge clk);
      k++;
    end
    chk("trip", 1, trip_q);
    #1 chk("op time", 3, expected_time_q);
    finish_test();
  end
endmodule // testbench
